// ===== hw/balfo_top.sv
// axi4-lite register front end around the byte alu
//
// Notes on behaviour
// - pointer op adds sign-extended 6-bit literal to chosen pointer; flags untouched.
// - pointer sum wraps modulo 65536, never saturates.
// - and-literal ands working register with 8-bit literal; only zero flag changes.
// - add-literal adds 8-bit literal into working register; updates carry, digit carry, zero.
// - and-file ands working register with file operand; only zero flag changes.
// - file ops: destination 0 writes working register, 1 writes file register.
// - add-file adds working and file operand to destination; updates carry, digit carry, zero.
// - shift moves file right one, old bit 0 to carry; updates carry, zero.
// - shift keeps bit 7 of result equal to original bit 7.
`timescale 1ns/1ns
`default_nettype none
module balfo_top
  import balfo_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // bus state
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic [ADDR_W-1:0] waddr_r, waddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // datapath state
  logic [7:0] work_r, work_nxt, file_r, file_nxt;
  logic [15:0] ptr0_r, ptr0_nxt, ptr1_r, ptr1_nxt;
  logic [2:0] flags_r, flags_nxt;
  logic [31:0] cmd_r, cmd_nxt, last_r, last_nxt;

  logic commit, wr_hit;
  logic [ADDR_W-1:0] wa, ra;
  logic [31:0] wmask, wmerged, rword;
  logic rd_hit;
  balfo_req_t req;
  balfo_res_t res;

  assign wa = {waddr_r[ADDR_W-1:2], 2'b00};
  assign ra = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  assign commit = aw_held_r & w_held_r & ~bvalid_r;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  // operands for the command that is being written
  always_comb begin
    wmerged = (cmd_r & ~wmask) | (wdata_r & wmask);
    req.op = wmerged[CMD_OP_LSB +: 3];
    req.dest = wmerged[CMD_DEST_BIT];
    req.literal = wmerged[CMD_LIT_LSB +: 8];
    req.work = work_r;
    req.file = file_r;
    req.ptr = wmerged[CMD_PSEL_BIT] ? ptr1_r : ptr0_r;
  end

  balfo_alu u_alu (
    .req(req),
    .res(res)
  );

  // write channel handshake
  always_comb begin
    aw_held_nxt = aw_held_r;
    w_held_nxt = w_held_r;
    waddr_nxt = waddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    if (s_axi_awvalid && awready_r) begin
      aw_held_nxt = 1'b1;
      waddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_held_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (commit) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    // one write in flight: no new address or data until the response is gone
    awready_nxt = ~aw_held_nxt & ~bvalid_nxt;
    wready_nxt = ~w_held_nxt & ~bvalid_nxt;
  end

  // read channel
  always_comb begin
    rd_hit = 1'b1;
    unique case (ra)
      OFS_CMD: rword = cmd_r;
      OFS_WORK: rword = {24'h000000, work_r};
      OFS_FLAGS: rword = {29'h00000000, flags_r};
      OFS_FILE: rword = {24'h000000, file_r};
      OFS_PTR0: rword = {16'h0000, ptr0_r};
      OFS_PTR1: rword = {16'h0000, ptr1_r};
      OFS_LAST: rword = last_r;
      default: begin
        rword = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rword;
      rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = ~rvalid_nxt;
  end

  // register file and command execution
  always_comb begin
    work_nxt = work_r;
    file_nxt = file_r;
    ptr0_nxt = ptr0_r;
    ptr1_nxt = ptr1_r;
    flags_nxt = flags_r;
    cmd_nxt = cmd_r;
    last_nxt = last_r;
    wr_hit = 1'b1;
    unique case (wa)
      OFS_CMD: begin
        if (commit) begin
          cmd_nxt = wmerged;
          if (res.wr_work) work_nxt = res.value;
          if (res.wr_file) file_nxt = res.value;
          if (res.wr_ptr && !wmerged[CMD_PSEL_BIT]) ptr0_nxt = res.ptr;
          if (res.wr_ptr && wmerged[CMD_PSEL_BIT]) ptr1_nxt = res.ptr;
          if (res.wr_c) flags_nxt[FLG_C] = res.c;
          if (res.wr_digit_carry) flags_nxt[FLG_DIGIT_CARRY] = res.digit_carry;
          if (res.wr_z) flags_nxt[FLG_Z] = res.z;
          last_nxt = 32'h00000000;
          last_nxt[7:0] = res.value;
          last_nxt[LAST_FADDR_LSB +: 7] = wmerged[CMD_FADDR_LSB +: 7];
          last_nxt[LAST_DEST_BIT] = res.wr_file;
          last_nxt[LAST_ILL_BIT] = res.illegal;
        end
      end
      OFS_WORK: if (commit) work_nxt = (work_r & ~wmask[7:0]) | (wdata_r[7:0] & wmask[7:0]);
      OFS_FLAGS: if (commit) flags_nxt = (flags_r & ~wmask[2:0]) | (wdata_r[2:0] & wmask[2:0]);
      OFS_FILE: if (commit) file_nxt = (file_r & ~wmask[7:0]) | (wdata_r[7:0] & wmask[7:0]);
      OFS_PTR0: if (commit) ptr0_nxt = (ptr0_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
      OFS_PTR1: if (commit) ptr1_nxt = (ptr1_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
      OFS_LAST: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      waddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
      work_r <= WORK_RST;
      file_r <= FILE_RST;
      ptr0_r <= PTR_RST;
      ptr1_r <= PTR_RST;
      flags_r <= FLAGS_RST;
      cmd_r <= 32'h00000000;
      last_r <= 32'h00000000;
    end else begin
      aw_held_r <= aw_held_nxt;
      w_held_r <= w_held_nxt;
      waddr_r <= waddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      work_r <= work_nxt;
      file_r <= file_nxt;
      ptr0_r <= ptr0_nxt;
      ptr1_r <= ptr1_nxt;
      flags_r <= flags_nxt;
      cmd_r <= cmd_nxt;
      last_r <= last_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule
`default_nettype wire

// ===== hw/balfo_pkg.sv
// constants and carrier types for the byte alu register block
package balfo_pkg;
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CMD = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_WORK = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FILE = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_PTR0 = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PTR1 = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_LAST = 8'h18;
  // command word fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DEST_BIT = 3;
  localparam int CMD_PSEL_BIT = 4;
  localparam int CMD_LIT_LSB = 8;
  localparam int CMD_FADDR_LSB = 16;
  // flag bits
  localparam int FLG_C = 0;
  localparam int FLG_DIGIT_CARRY = 1;
  localparam int FLG_Z = 2;
  // last-result word fields
  localparam int LAST_FADDR_LSB = 8;
  localparam int LAST_DEST_BIT = 15;
  localparam int LAST_ILL_BIT = 16;
  // operation codes
  localparam logic [2:0] OP_ADD_LITERAL_TO_POINTER = 3'h0;
  localparam logic [2:0] OP_AND_LITERAL_WORKING = 3'h1;
  localparam logic [2:0] OP_ADD_LITERAL_WORKING = 3'h2;
  localparam logic [2:0] OP_AND_WORKING_FILE = 3'h3;
  localparam logic [2:0] OP_ADD_WORKING_FILE = 3'h4;
  localparam logic [2:0] OP_ARITH_SHIFT_RIGHT_FILE = 3'h5;
  // reset values
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [7:0] FILE_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [2:0] FLAGS_RST = 3'h0;

  typedef struct packed {
    logic [2:0] op;
    logic dest;
    logic [7:0] literal;
    logic [7:0] work;
    logic [7:0] file;
    logic [15:0] ptr;
  } balfo_req_t;

  typedef struct packed {
    logic [7:0] value;
    logic [15:0] ptr;
    logic c;
    logic digit_carry;
    logic z;
    logic wr_c;
    logic wr_digit_carry;
    logic wr_z;
    logic wr_work;
    logic wr_file;
    logic wr_ptr;
    logic illegal;
  } balfo_res_t;
endpackage

// ===== hw/balfo_alu.sv
// combinational byte alu: literal, file and pointer operations
`timescale 1ns/1ns
`default_nettype none
module balfo_alu
  import balfo_pkg::*;
(
  input wire balfo_req_t req,
  output balfo_res_t res
);
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [7:0] operand;
  logic [15:0] lit_ext;

  always_comb begin
    operand = (req.op == OP_ADD_LITERAL_WORKING || req.op == OP_AND_LITERAL_WORKING) ? req.literal : req.file;
    sum9 = {1'b0, req.work} + {1'b0, operand};
    sum5 = {1'b0, req.work[3:0]} + {1'b0, operand[3:0]};
    lit_ext = {{10{req.literal[5]}}, req.literal[5:0]};
    res = '0;
    unique case (req.op)
      OP_ADD_LITERAL_TO_POINTER: begin
        // 16-bit add drops carry, so the pointer wraps modulo 65536
        res.ptr = req.ptr + lit_ext;
        res.wr_ptr = 1'b1;
      end
      OP_AND_LITERAL_WORKING: begin
        res.value = req.work & req.literal;
        res.wr_work = 1'b1;
        res.wr_z = 1'b1;
      end
      OP_ADD_LITERAL_WORKING: begin
        res.value = sum9[7:0];
        res.wr_work = 1'b1;
        res.wr_c = 1'b1;
        res.wr_digit_carry = 1'b1;
        res.wr_z = 1'b1;
      end
      OP_AND_WORKING_FILE: begin
        res.value = req.work & req.file;
        res.wr_z = 1'b1;
      end
      OP_ADD_WORKING_FILE: begin
        res.value = sum9[7:0];
        res.wr_c = 1'b1;
        res.wr_digit_carry = 1'b1;
        res.wr_z = 1'b1;
      end
      OP_ARITH_SHIFT_RIGHT_FILE: begin
        res.value = {req.file[7], req.file[7:1]};
        res.wr_c = 1'b1;
        res.wr_z = 1'b1;
      end
      default: res.illegal = 1'b1;
    endcase
    // file ops route by destination bit
    if (req.op == OP_AND_WORKING_FILE || req.op == OP_ADD_WORKING_FILE || req.op == OP_ARITH_SHIFT_RIGHT_FILE) begin
      res.wr_work = ~req.dest;
      res.wr_file = req.dest;
    end
    res.c = (req.op == OP_ARITH_SHIFT_RIGHT_FILE) ? req.file[0] : sum9[8];
    res.digit_carry = sum5[4];
    res.z = (res.value == 8'h00);
  end
endmodule
`default_nettype wire

// ===== testbench/balfo_top_properties.sv
// bus-side checks on the byte alu register block
`timescale 1ns/1ns
`default_nettype none
module balfo_top_properties
  import balfo_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence read_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // both halves held at the handshake edge, commit next edge, response visible after that
  a_write_answer: assert property (write_taken |-> ##2 s_axi_bvalid) else $error("no write response");
  a_read_answer: assert property (read_taken |=> s_axi_rvalid) else $error("no read response");
  a_unmapped_read: assert property (read_taken ##0 s_axi_araddr[7:2] > 6'h06
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  a_mapped_read: assert property (read_taken ##0 s_axi_araddr[7:2] <= 6'h06
    |=> s_axi_rresp == RESP_OKAY) else $error("mapped read refused");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken during data");
  a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid)
    else $error("response out of reset");
endmodule
`default_nettype wire

// ===== testbench/balfo_axi_master.sv
// axi4-lite master standing for the software side
`timescale 1ns/1ns
`default_nettype none
module balfo_axi_master
  import balfo_pkg::*;
(
  input wire logic aclk,
  output logic [ADDR_W-1:0] ad,
  output logic awv,
  input wire logic awr,
  output logic [31:0] wd,
  output logic wv,
  input wire logic wrd,
  input wire logic [1:0] br,
  input wire logic bv,
  output logic bry,
  output logic arv,
  input wire logic arr,
  input wire logic [31:0] rd,
  input wire logic [1:0] rr,
  input wire logic rv,
  output logic rry
);
  initial begin
    {awv, wv, bry, arv, rry} = 5'h00;
    ad = 8'h00;
    wd = 32'h0;
  end
  // one address bus serves both channels: only one access is ever open
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    ad <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (awv && !awr || wv && !wrd);
    // late ready keeps the response held for a while
    repeat ($urandom_range(2)) @(posedge aclk);
    bry <= 1'b1;
    do @(posedge aclk); while (!bv);
    r = br;
    bry <= 1'b0;
  endtask
  task automatic rdt(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    ad <= a;
    arv <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    repeat ($urandom_range(2)) @(posedge aclk);
    rry <= 1'b1;
    do @(posedge aclk); while (!rv);
    d = rd;
    r = rr;
    rry <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== testbench/balfo_tb_top.sv
// self-checking bench for the byte alu register block
`timescale 1ns/1ns
`default_nettype none
module balfo_tb_top
  import balfo_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] ad, w, f, k;
  logic [31:0] wd, rd, got;
  logic [1:0] br, rr, rsp;
  logic awv, awr, wv, wrd, bv, bry, arv, arr, rv, rry, d, s;
  logic [2:0] fl, op;
  logic [15:0] p0, p1;
  logic [58:0] e;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  logic [43:0] cor [8] = '{44'h0_00_00_3f_0000, 44'h0_00_00_01_ffff, 44'h0_00_00_20_0010,
    44'h2_ff_00_01_0000, 44'h4_0f_01_00_0000, 44'h5_00_81_00_0000, 44'h3_f0_0f_00_0000, 44'h6_12_34_56_789a};
  initial begin
    forever #4 aclk = ~aclk;
  end
  balfo_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(ad), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ad),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rry));
  balfo_axi_master m (.aclk(aclk), .ad(ad), .awv(awv), .awr(awr), .wd(wd), .wv(wv), .wrd(wrd), .br(br),
    .bv(bv), .bry(bry), .arv(arv), .arr(arr), .rd(rd), .rr(rr), .rv(rv), .rry(rry));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] x, input logic [1:0] xr);
    m.rdt(a, got, rsp);
    chk({30'h0, rsp}, {30'h0, xr});
    chk(got, x);
  endtask
  task automatic wrk(input logic [7:0] a, input logic [31:0] x);
    m.wr(a, x, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_OKAY});
  endtask
  function automatic logic [58:0] model(input logic [2:0] o, input logic dd, input logic ss,
    input logic [7:0] kk, input logic [7:0] ww, input logic [7:0] ff, input logic [2:0] fg,
    input logic [15:0] q0, input logic [15:0] q1);
    logic [8:0] sm;
    logic [4:0] lo;
    logic [7:0] b;
    logic [7:0] r;
    logic [15:0] q;
    b = (o < 3'h3) ? kk : ff;
    sm = ww + b;
    lo = ww[3:0] + b[3:0];
    r = ww & b;
    q = (ss ? q1 : q0) + {{10{kk[5]}}, kk[5:0]};
    case (o)
      OP_ADD_LITERAL_TO_POINTER: if (ss) q1 = q; else q0 = q;
      OP_AND_LITERAL_WORKING, OP_AND_WORKING_FILE: fg[FLG_Z] = (r == 8'h00);
      OP_ADD_LITERAL_WORKING, OP_ADD_WORKING_FILE: begin
        r = sm[7:0];
        fg = {r == 8'h00, lo[4], sm[8]};
      end
      OP_ARITH_SHIFT_RIGHT_FILE: begin
        r = {ff[7], ff[7:1]};
        fg = {r == 8'h00, fg[FLG_DIGIT_CARRY], ff[0]};
      end
      default: ;
    endcase
    if (o == OP_AND_LITERAL_WORKING || o == OP_ADD_LITERAL_WORKING) ww = r;
    else if (o inside {[3'h3:3'h5]}) begin
      if (dd) ff = r; else ww = r;
    end
    // pointer and illegal codes leave no byte result behind
    if (o == OP_ADD_LITERAL_TO_POINTER || o > OP_ARITH_SHIFT_RIGHT_FILE) r = 8'h00;
    return {r, ww, ff, fg, q0, q1};
  endfunction
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'h88b6));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 7; i++) rchk(8'(4 * i), 32'h0, RESP_OKAY);
    rchk(8'h20, 32'h0, RESP_SLVERR);
    m.wr(8'h1c, 32'hffffffff, rsp);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    for (int i = 0; i < 60; i++) begin
      {w, f, k, p0, p1} = 56'({$urandom, $urandom});
      {op, d, s, fl} = 8'($urandom);
      // corners first: pointer wrap both ways, carries, sign fill, illegal code
      if (i < 8) {op, w, f, k, p0, s} = {43'(cor[i]), 1'b0};
      wrk(OFS_WORK, {24'h0, w});
      wrk(OFS_FILE, {24'h0, f});
      wrk(OFS_FLAGS, {29'h0, fl});
      wrk(OFS_PTR0, {16'h0, p0});
      wrk(OFS_PTR1, {16'h0, p1});
      e = model(op, d, s, k, w, f, fl, p0, p1);
      wrk(OFS_CMD, {9'h0, 7'(i), k, 3'h0, s, d, op});
      rchk(OFS_WORK, {24'h0, e[50:43]}, RESP_OKAY);
      rchk(OFS_FILE, {24'h0, e[42:35]}, RESP_OKAY);
      rchk(OFS_FLAGS, {29'h0, e[34:32]}, RESP_OKAY);
      rchk(OFS_PTR0, {16'h0, e[31:16]}, RESP_OKAY);
      rchk(OFS_PTR1, {16'h0, e[15:0]}, RESP_OKAY);
      rchk(OFS_LAST, {15'h0, (op > OP_ARITH_SHIFT_RIGHT_FILE), (d && (op inside {[3'h3:3'h5]})),
        7'(i), e[58:51]}, RESP_OKAY);
    end
    print_verdict();
  end
endmodule
bind balfo_top balfo_top_properties u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
`default_nettype wire
